// File: dctom_pkg.sv
// Package with constants and types shared by the torque-off monitor files.
package dctom_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned PULSE_IGNORE_US = 2_000;
   localparam int unsigned DETECT_MIN_MS = 1_600;
   localparam int unsigned DETECT_MAX_MS = 3_000;
   localparam int unsigned DETECT_SET_MS = 2_300;
   // The pulse-ignore and detect set times convert to cycles through truncated whole cycles per microsecond or millisecond.
   localparam int unsigned PULSE_IGNORE_CYC = (PULSE_IGNORE_US * (CLK_HZ / 1_000_000));
   localparam int unsigned DETECT_SET_CYC = DETECT_SET_MS * (CLK_HZ / 1_000);
   localparam int unsigned CNT_W = 32;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_MISMATCH_CNT = 8'h10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // Control fields.
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_FAULT_INJ_BIT = 1;

   // Status fields.
   localparam int unsigned ST_CHA_BIT = 0;
   localparam int unsigned ST_CHB_BIT = 1;
   localparam int unsigned ST_SAFE_BIT = 2;
   localparam int unsigned ST_TRIP_BIT = 3;
   localparam int unsigned ST_MISMATCH_BIT = 4;
   localparam int unsigned ST_LATCHED_BIT = 5;
   localparam int unsigned ST_PERMIT_BIT = 6;
   localparam int unsigned ST_POWER_BIT = 7;

   // Interrupt fields, shared by status and mask.
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_TRIP_BIT = 0;
   localparam int unsigned IRQ_MISMATCH_BIT = 1;
   localparam int unsigned IRQ_LATCHED_BIT = 2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      DCTOM_SAFE,
      DCTOM_RUN,
      DCTOM_MISMATCH,
      DCTOM_LATCHED
   } dctom_state_t;

endpackage : dctom_pkg

// File: dctom_chan_if.sv
// Interface carrying raw and filtered stop channels between filter and monitor.
interface dctom_chan_if;
   logic [1:0] raw;
   logic [1:0] filt;

   modport filter (
      input raw,
      output filt
   );

   modport monitor (
      output raw,
      input filt
   );
endinterface : dctom_chan_if

// File: dctom_stop_filter.sv
// Per-channel filter that hides short low-going test pulses.
module dctom_stop_filter
   import dctom_pkg::*;
#(
   parameter int unsigned FILT_CYC = PULSE_IGNORE_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Channels
   dctom_chan_if.filter ch
);

   // ****************************************************************
   // Low-pulse rejection
   // ****************************************************************
   // A high level passes at once; a low level passes only after it has
   // stood for the full window, so test pulses never reach the monitor.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         logic [CNT_W-1:0] cnt_reg;
         logic [CNT_W-1:0] cnt_next;
         logic filt_reg;
         logic filt_next;

         always_comb begin
            cnt_next = cnt_reg;
            filt_next = filt_reg;
            if (ch.raw[g]) begin
               cnt_next = '0;
               filt_next = 1'b1;
            end else if (filt_reg) begin
               if (cnt_reg >= CNT_W'(FILT_CYC - 1)) begin
                  filt_next = 1'b0;
                  cnt_next = '0;
               end else begin
                  cnt_next = cnt_reg + CNT_W'(1);
               end
            end
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               cnt_reg <= '0;
               filt_reg <= 1'b0;
            end else begin
               cnt_reg <= cnt_next;
               filt_reg <= filt_next;
            end
         end

         assign ch.filt[g] = filt_reg;
      end
   endgenerate

endmodule : dctom_stop_filter

// File: dctom_monitor.sv
// Dual-channel torque-off monitor with Wishbone registers and interrupt.
module dctom_monitor
   import dctom_pkg::*;
#(
   parameter int unsigned FILT_CYC = PULSE_IGNORE_CYC,
   parameter int unsigned DETECT_CYC = DETECT_SET_CYC
) (
   // Clock and power-on reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Safety channels and internal self-check
   input wire logic channel_a_stop_input_i,
   input wire logic channel_b_stop_input_i,
   input wire logic internal_fault_i,
   // Drive control
   output logic power_enable_o,
   output logic start_block_o,
   output logic trip_o,
   output logic latched_fault_o,
   // Isolated status relay, on means safe state
   output logic safe_status_output_pos_o,
   output logic safe_status_output_neg_o,
   // Interrupt
   output logic irq_o
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      hit = (adr == off);
   endfunction : hit

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      merge = r;
   endfunction : merge

   // ****************************************************************
   // Channel filtering
   // ****************************************************************
   dctom_chan_if chan ();

   assign chan.raw = {channel_b_stop_input_i, channel_a_stop_input_i};

   dctom_stop_filter #(
      .FILT_CYC(FILT_CYC)
   ) u_filter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ch(chan)
   );

   logic cha;
   logic chb;
   logic agree;
   assign cha = chan.filt[0];
   assign chb = chan.filt[1];
   assign agree = (cha == chb);

   // ****************************************************************
   // Bus access decode
   // ****************************************************************
   logic wb_req;
   logic wb_wr;
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_req && wb_we_i;

   // ****************************************************************
   // Monitor state
   // ****************************************************************
   dctom_state_t state_reg;
   dctom_state_t state_next;
   logic [CNT_W-1:0] mm_cnt_reg;
   logic [CNT_W-1:0] mm_cnt_next;
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic internal_fault;

   // A forced fault from software exercises the same latch path as a
   // self-check failure, so the latch can be proven without a broken board.
   assign internal_fault = internal_fault_i || ctrl_reg[CTRL_FAULT_INJ_BIT];

   always_comb begin
      state_next = state_reg;
      mm_cnt_next = mm_cnt_reg;
      ctrl_next = ctrl_reg;
      if (wb_wr && hit(wb_adr_i, REG_CTRL)) begin
         ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_0003;
      end
      case (state_reg)
         DCTOM_LATCHED: begin
            // No input combination leaves this state; only reset does.
            state_next = DCTOM_LATCHED;
            mm_cnt_next = mm_cnt_reg;
         end
         default: begin
            if (internal_fault) begin
               state_next = DCTOM_LATCHED;
            end else if (agree) begin
               mm_cnt_next = '0;
               state_next = cha ? DCTOM_RUN : DCTOM_SAFE;
            end else if (mm_cnt_reg >= CNT_W'(DETECT_CYC - 1)) begin
               state_next = DCTOM_LATCHED;
            end else begin
               mm_cnt_next = mm_cnt_reg + CNT_W'(1);
               state_next = DCTOM_MISMATCH;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= DCTOM_SAFE;
         mm_cnt_reg <= '0;
         ctrl_reg <= CTRL_RESET;
      end else begin
         state_reg <= state_next;
         mm_cnt_reg <= mm_cnt_next;
         ctrl_reg <= ctrl_next;
      end
   end

   // ****************************************************************
   // Drive outputs
   // ****************************************************************
   logic permit;
   logic safe_on;
   logic power_next;
   logic trip_next;
   logic block_next;
   logic safe_next;
   logic latched_next;
   logic power_reg;
   logic trip_reg;
   logic block_reg;
   logic safe_reg;
   logic latched_reg;

   assign permit = (state_reg == DCTOM_RUN);
   assign safe_on = (state_reg == DCTOM_SAFE);

   always_comb begin
      power_next = permit && ctrl_reg[CTRL_RUN_BIT];
      block_next = !permit;
      trip_next = !permit;
      safe_next = safe_on;
      latched_next = (state_reg == DCTOM_LATCHED);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Held in the unpowered state: no motor power, relay open.
         power_reg <= 1'b0;
         block_reg <= 1'b1;
         trip_reg <= 1'b0;
         safe_reg <= 1'b0;
         latched_reg <= 1'b0;
      end else begin
         power_reg <= power_next;
         block_reg <= block_next;
         trip_reg <= trip_next;
         safe_reg <= safe_next;
         latched_reg <= latched_next;
      end
   end

   assign power_enable_o = power_reg;
   assign start_block_o = block_reg;
   assign trip_o = trip_reg;
   assign latched_fault_o = latched_reg;
   assign safe_status_output_pos_o = safe_reg;
   assign safe_status_output_neg_o = !safe_reg;

   // ****************************************************************
   // Interrupt status and mask
   // ****************************************************************
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_stat_next;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_mask_next;
   logic [IRQ_W-1:0] events;
   logic [IRQ_W-1:0] w1c;

   always_comb begin
      events = '0;
      events[IRQ_TRIP_BIT] = trip_next && !trip_reg;
      events[IRQ_MISMATCH_BIT] = (state_next == DCTOM_MISMATCH) && (state_reg != DCTOM_MISMATCH);
      events[IRQ_LATCHED_BIT] = latched_next && !latched_reg;
      w1c = '0;
      if (wb_wr && hit(wb_adr_i, REG_IRQ_STAT) && wb_sel_i[0]) begin
         w1c = wb_dat_i[IRQ_W-1:0];
      end
      // A new event in the clearing cycle survives the clear.
      irq_stat_next = (irq_stat_reg & ~w1c) | events;
      irq_mask_next = irq_mask_reg;
      if (wb_wr && hit(wb_adr_i, REG_IRQ_MASK) && wb_sel_i[0]) begin
         irq_mask_next = wb_dat_i[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= MASK_RESET[IRQ_W-1:0];
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   assign irq_o = |(irq_stat_reg & irq_mask_reg);

   // ****************************************************************
   // Wishbone answer
   // ****************************************************************
   logic [31:0] status_word;
   logic [31:0] rd_data;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;
   logic ack_reg;
   logic ack_next;

   always_comb begin
      status_word = '0;
      status_word[ST_CHA_BIT] = cha;
      status_word[ST_CHB_BIT] = chb;
      status_word[ST_SAFE_BIT] = safe_reg;
      status_word[ST_TRIP_BIT] = trip_reg;
      status_word[ST_MISMATCH_BIT] = (state_reg == DCTOM_MISMATCH);
      status_word[ST_LATCHED_BIT] = latched_reg;
      status_word[ST_PERMIT_BIT] = permit;
      status_word[ST_POWER_BIT] = power_reg;
      if (hit(wb_adr_i, REG_CTRL)) begin
         rd_data = ctrl_reg;
      end else if (hit(wb_adr_i, REG_STATUS)) begin
         rd_data = status_word;
      end else if (hit(wb_adr_i, REG_IRQ_STAT)) begin
         rd_data = {{(32-IRQ_W){1'b0}}, irq_stat_reg};
      end else if (hit(wb_adr_i, REG_IRQ_MASK)) begin
         rd_data = {{(32-IRQ_W){1'b0}}, irq_mask_reg};
      end else if (hit(wb_adr_i, REG_MISMATCH_CNT)) begin
         rd_data = mm_cnt_reg;
      end else begin
         rd_data = UNMAPPED_DATA;
      end
      ack_next = wb_req;
      dat_next = dat_reg;
      if (wb_req && !wb_we_i) begin
         dat_next = rd_data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end else begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

endmodule : dctom_monitor

// File: dctom_monitor_assertions.sv
// Port-level checker for the torque-off monitor.
module dctom_monitor_assertions #(
   parameter int unsigned FILT_CYC = 4,
   parameter int unsigned DETECT_CYC = 20
) (
   // Clock, reset and bus handshake
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Channels and drive outputs
   input wire logic channel_a_stop_input_i,
   input wire logic internal_fault_i,
   input wire logic power_enable_o,
   input wire logic start_block_o,
   input wire logic trip_o,
   input wire logic latched_fault_o,
   input wire logic safe_status_output_pos_o,
   input wire logic safe_status_output_neg_o
);
   // ****************************************************************
   // Mismatch length seen at the outputs
   // ****************************************************************
   int unsigned mis_reg;
   int unsigned mis_next;
   always_comb begin
      mis_next = (trip_o && !safe_status_output_pos_o && !latched_fault_o) ? mis_reg + 1 : 0;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mis_reg <= 0;
      end else begin
         mis_reg <= mis_next;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack;
      s_req |=> s_ack;
   endproperty
   property p_relay;
      safe_status_output_neg_o == !safe_status_output_pos_o;
   endproperty
   property p_safe;
      safe_status_output_pos_o |-> trip_o && start_block_o && !power_enable_o && !latched_fault_o;
   endproperty
   property p_run;
      power_enable_o |-> !start_block_o && !trip_o && !safe_status_output_pos_o && !latched_fault_o;
   endproperty
   property p_latch;
      latched_fault_o |-> trip_o && start_block_o && !power_enable_o && !safe_status_output_pos_o;
   endproperty
   property p_hold;
      latched_fault_o |=> latched_fault_o;
   endproperty
   property p_pulse;
      $fell(channel_a_stop_input_i) && power_enable_o && !wb_cyc_i && !internal_fault_i |-> power_enable_o [*2];
   endproperty
   property p_int;
      internal_fault_i |-> ##[1:3] latched_fault_o;
   endproperty
   property p_bound;
      mis_reg <= DETECT_CYC + 2;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle after request");
   a_relay: assert property (p_relay) else $error("relay pair not complementary");
   a_safe: assert property (p_safe) else $error("safe relay on outside safe state");
   a_run: assert property (p_run) else $error("power enabled while tripped");
   a_latch: assert property (p_latch) else $error("latched fault outputs wrong");
   a_hold: assert property (p_hold) else $error("latched fault cleared without reset");
   a_pulse: assert property (p_pulse) else $error("short low pulse dropped power");
   a_int: assert property (p_int) else $error("internal fault not latched");
   a_bound: assert property (p_bound) else $error("mismatch outlived detect time");
endmodule : dctom_monitor_assertions

bind dctom_monitor dctom_monitor_assertions #(.FILT_CYC(FILT_CYC), .DETECT_CYC(DETECT_CYC)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .channel_a_stop_input_i(channel_a_stop_input_i), .internal_fault_i(internal_fault_i),
   .power_enable_o(power_enable_o), .start_block_o(start_block_o), .trip_o(trip_o),
   .latched_fault_o(latched_fault_o), .safe_status_output_pos_o(safe_status_output_pos_o),
   .safe_status_output_neg_o(safe_status_output_neg_o));

// File: dctom_relay_model.sv
// Behavioural model of the two safety relay contacts feeding the stop channels.
module dctom_relay_model (
   // Clock
   input wire logic clk_i,
   // Commands from the safety controller
   input wire logic a_cmd_i,
   input wire logic b_cmd_i,
   input wire logic skew_i,
   // Contact outputs
   output logic a_o,
   output logic b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic b_dly;
   // Contacts switch together; a slow contact on b lags one cycle when asked.
   always_ff @(posedge clk_i) begin
      a_o <= a_cmd_i;
      b_dly <= b_cmd_i;
      b_o <= skew_i ? b_dly : b_cmd_i;
   end
endmodule : dctom_relay_model

// File: tb_dctom_monitor.sv
// Self-checking bench for the torque-off monitor.
module tb_dctom_monitor import dctom_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Signals and helpers
   // ****************************************************************
   localparam int unsigned F = 4;
   localparam int unsigned D = 20;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, irq;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0000_0000, wb_rdat;
   logic a_cmd = 1'b0, b_cmd = 1'b0, skew = 1'b0, a_ch, b_ch, int_fault = 1'b0;
   logic power, block, trip, latched, pos, neg;
   int err_count = 0;
   int samples_checked = 0;
   int tick = 0;
   dctom_relay_model u_relay (.clk_i(clk_i), .a_cmd_i(a_cmd), .b_cmd_i(b_cmd), .skew_i(skew), .a_o(a_ch), .b_o(b_ch));
   dctom_monitor #(.FILT_CYC(F), .DETECT_CYC(D)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .channel_a_stop_input_i(a_ch), .channel_b_stop_input_i(b_ch), .internal_fault_i(int_fault),
      .power_enable_o(power), .start_block_o(block), .trip_o(trip), .latched_fault_o(latched),
      .safe_status_output_pos_o(pos), .safe_status_output_neg_o(neg), .irq_o(irq));
   always #4 clk_i = ~clk_i;
   // The run needs a few hundred cycles; a hang is cut off well beyond that.
   always @(posedge clk_i) begin
      tick <= tick + 1;
      if (tick == 3000) begin
         err_count++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask : chk_word
   task automatic chk_pins(input logic [5:0] exp);
      chk_word({26'h0, exp}, {26'h0, power, block, trip, latched, pos, neg});
   endtask : chk_pins
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= wd;
      wb_sel <= 4'hF;
      @(posedge clk_i);
      while (wb_ack !== 1'b1) @(posedge clk_i);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb_xfer
   task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
      logic [31:0] r;
      wb_xfer(1'b1, adr, wd, r);
   endtask : wr
   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] r;
      wb_xfer(1'b0, adr, 32'h0000_0000, r);
      chk_word(exp, r);
   endtask : rd_chk
   task automatic pwr_cycle();
      rst_i <= 1'b1;
      cyc(3);
      chk_pins(6'h11);
      cyc(1);
      rst_i <= 1'b0;
      cyc(5);
   endtask : pwr_cycle
   task automatic go_run();
      a_cmd <= 1'b1;
      b_cmd <= 1'b1;
      cyc(6);
      wr(REG_CTRL, 32'h0000_0001);
      cyc(4);
   endtask : go_run
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      pwr_cycle();
      chk_pins(6'h1A);
      rd_chk(REG_STATUS, 32'h0000_000C);
      rd_chk(REG_CTRL, CTRL_RESET);
      rd_chk(REG_IRQ_MASK, MASK_RESET);
      wr(8'h40, 32'hFFFF_FFFF);
      rd_chk(8'h40, UNMAPPED_DATA);
      go_run();
      chk_pins(6'h21);
      rd_chk(REG_STATUS, 32'h0000_00C3);
      a_cmd <= 1'b0;
      cyc(F - 1);
      a_cmd <= 1'b1;
      cyc(8);
      chk_pins(6'h21);
      // Two mismatches that together outlast the threshold but each stays short.
      for (int k = 0; k < 2; k++) begin
         a_cmd <= 1'b0;
         cyc(F + 12);
         chk_pins(6'h19);
         // Twelve mismatched cycles have been counted when the read is taken, in both rounds.
         rd_chk(REG_MISMATCH_CNT, 32'h0000_000C);
         a_cmd <= 1'b1;
         cyc(6);
      end
      chk_pins(6'h21);
      rd_chk(REG_IRQ_STAT, 32'h0000_0003);
      chk_word(32'h0000_0000, {31'h0, irq});
      wr(REG_IRQ_MASK, 32'h0000_0007);
      chk_word(32'h0000_0001, {31'h0, irq});
      wr(REG_IRQ_STAT, 32'h0000_0007);
      rd_chk(REG_IRQ_STAT, 32'h0000_0000);
      chk_word(32'h0000_0000, {31'h0, irq});
      a_cmd <= 1'b0;
      cyc(F + D + 10);
      chk_pins(6'h1D);
      chk_word(32'h0000_0001, {31'h0, irq});
      a_cmd <= 1'b1;
      cyc(8);
      chk_pins(6'h1D);
      a_cmd <= 1'b0;
      b_cmd <= 1'b0;
      cyc(8);
      chk_pins(6'h1D);
      pwr_cycle();
      chk_pins(6'h1A);
      skew <= 1'b1;
      for (int j = 0; j < 2; j++) begin
         go_run();
         if (j == 0) begin
            int_fault <= 1'b1;
            cyc(1);
            int_fault <= 1'b0;
         end else begin
            wr(REG_CTRL, 32'h0000_0003);
         end
         cyc(4);
         chk_pins(6'h1D);
         pwr_cycle();
      end
      conclude();
   end
endmodule : tb_dctom_monitor
